// ### core/hsd_pkg.sv
// Shared constants and types for the headset detect sequencer.
package hsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timebase.
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Intervals in milliseconds, with their counts in timebase ticks.
  localparam int INS_DEBOUNCE_MS = 90;
  localparam int REM_DEBOUNCE_MS = 50;
  localparam int DETECT_MS = 80;
  localparam int POWERUP_MS = 20;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] INS_TICKS = TMR_W'(INS_DEBOUNCE_MS * 1000000 / TICK_NS);
  localparam logic [TMR_W-1:0] REM_TICKS = TMR_W'(REM_DEBOUNCE_MS * 1000000 / TICK_NS);
  localparam logic [TMR_W-1:0] DET_TICKS = TMR_W'(DETECT_MS * 1000000 / TICK_NS);
  localparam logic [TMR_W-1:0] PWR_TICKS = TMR_W'(POWERUP_MS * 1000000 / TICK_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  typedef enum logic [2:0] {
    HSD_POWERUP,
    HSD_SLEEP,
    HSD_DEBOUNCE,
    HSD_DETECT,
    HSD_ROUTE,
    HSD_ATTACHED,
    HSD_REMOVE_WAIT
  } hsd_state_t;

  // Switch controls driven to the analog section.
  typedef struct packed {
    logic gnd_sleeve;     // Ground switch FET on sleeve.
    logic gnd_ring2;      // Ground switch FET on ring2.
    logic micbias_sleeve; // Mic bias pin routed to sleeve.
    logic micbias_ring2;  // Mic bias pin routed to ring2.
    logic depletion_on;   // Depletion ground FETs conducting.
  } hsd_sw_t;

  localparam hsd_sw_t SW_SLEEP = 5'h01;
  localparam hsd_sw_t SW_OFF = 5'h00;
  localparam hsd_sw_t SW_THREE = 5'h18;
  // A mic on one contact takes the bias there and ground on the other contact.
  localparam hsd_sw_t SW_MIC_SLEEVE = 5'h0C;
  localparam hsd_sw_t SW_MIC_RING2 = 5'h12;

endpackage

// ### core/hsd_seq.sv
// Headset jack insertion and removal sequencer.
// Function
// - Start insertion debounce once jack goes low.
// - Jack high during debounce restarts the timer.
// - Debounce expiry starts configuration detection immediately.
// - Route switches before asserting the interrupt.
// - Mic_found_n drops with interrupt, after routing.
// - Interrupt register read clears the interrupt.
// - Removal changes switches at once, asserts interrupt.
// - Removal releases mic_found_n output.
// - Removal debounce then sleep unless manual control.
// - Jack fall to interrupt within 210 ms.
// - Host interface ready within 25 ms.
// - Depletion FETs on after 50 ms removal wait.
// - Removal aborts debounce, detection or routing.
// - Manual control keeps switches on removal.
// - Host command can also start detection.
module hsd_seq
  import hsd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Jack and analog sense pins.
  input wire logic jack_detect_n_i,
  input wire logic mic_on_sleeve_i,
  input wire logic mic_on_ring2_i,
  // Host side controls from the serial interface logic.
  input wire logic host_start_i,
  input wire logic int_reg_read_i,
  input wire logic manual_ctrl_i,
  // Outputs to host and analog section.
  output logic int_n_o,
  output logic mic_found_n_o,
  output logic host_ready_o,
  output logic sleep_o,
  output hsd_sw_t sw_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds only stage two.
  logic [2:0] jack_s1_r, jack_s2_r;
  logic [2:0] pin_nxt;
  logic jack_hi;

  always_comb begin
    pin_nxt = {jack_detect_n_i, mic_on_sleeve_i, mic_on_ring2_i};
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      jack_s1_r <= 3'h4;
      jack_s2_r <= 3'h4;
    end else begin
      jack_s1_r <= pin_nxt;
      jack_s2_r <= jack_s1_r;
    end
  end

  assign jack_hi = jack_s2_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Free running timebase; a one millisecond tick keeps every interval
  // within a tick of its figure at little counter cost.
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;

  always_comb begin
    tick = (tick_cnt_r == 32'(TICK_LEN - 1));
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  hsd_state_t state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  hsd_sw_t sw_r, sw_nxt;
  logic int_pend_r, int_pend_nxt;
  logic mic_n_r, mic_n_nxt;
  logic ready_r, ready_nxt;
  logic int_set, mic_set;

  // True on the tick that ends an interval of n ticks.
  function automatic logic expired(input logic [TMR_W-1:0] t, input logic [TMR_W-1:0] n,
                                   input logic tk);
    expired = tk && (t == n - TMR_W'(1));
  endfunction

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tick ? tmr_r + TMR_W'(1) : tmr_r;
    sw_nxt = sw_r;
    ready_nxt = ready_r;
    int_set = 1'b0;
    mic_set = 1'b0;
    mic_n_nxt = mic_n_r;
    case (state_r)
      HSD_POWERUP: begin
        if (expired(tmr_r, PWR_TICKS, tick)) begin
          ready_nxt = 1'b1;
          state_nxt = HSD_SLEEP;
        end
      end
      HSD_SLEEP: begin
        tmr_nxt = '0;
        if (host_start_i) begin
          state_nxt = HSD_DETECT;
        end else if (!jack_hi) begin
          state_nxt = HSD_DEBOUNCE;
        end
      end
      HSD_DEBOUNCE: begin
        if (jack_hi) begin
          state_nxt = HSD_SLEEP;
          tmr_nxt = '0;
        end else if (expired(tmr_r, INS_TICKS, tick)) begin
          state_nxt = HSD_DETECT;
          tmr_nxt = '0;
        end
      end
      HSD_DETECT: begin
        if (expired(tmr_r, DET_TICKS, tick)) begin
          state_nxt = HSD_ROUTE;
          case (jack_s2_r[1:0])
            2'h2: sw_nxt = SW_MIC_SLEEVE;
            2'h1: sw_nxt = SW_MIC_RING2;
            default: sw_nxt = SW_THREE;
          endcase
        end
      end
      HSD_ROUTE: begin
        // Switches were latched last cycle, so they settle first.
        state_nxt = HSD_ATTACHED;
        int_set = 1'b1;
        mic_set = sw_r.micbias_sleeve | sw_r.micbias_ring2;
        if (mic_set) begin
          mic_n_nxt = 1'b0;
        end
      end
      HSD_ATTACHED: begin
        tmr_nxt = '0;
      end
      HSD_REMOVE_WAIT: begin
        if (!jack_hi) begin
          state_nxt = HSD_DEBOUNCE;
          tmr_nxt = '0;
        end else if (expired(tmr_r, REM_TICKS, tick)) begin
          if (!manual_ctrl_i) begin
            sw_nxt = SW_SLEEP;
            state_nxt = HSD_SLEEP;
          end
        end
      end
      default: begin
        state_nxt = HSD_POWERUP;
      end
    endcase
    // Removal overrides whatever detection or routing was doing.
    if (jack_hi && !host_start_i &&
        (state_r == HSD_DETECT || state_r == HSD_ROUTE || state_r == HSD_ATTACHED)) begin
      state_nxt = HSD_REMOVE_WAIT;
      tmr_nxt = '0;
      int_set = 1'b1;
      mic_n_nxt = 1'b1;
      sw_nxt = manual_ctrl_i ? sw_r : SW_OFF;
    end
    // A new event wins over a simultaneous acknowledge read.
    int_pend_nxt = int_set | (int_pend_r & ~int_reg_read_i);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= HSD_POWERUP;
      tmr_r <= '0;
      sw_r <= SW_SLEEP;
      int_pend_r <= 1'b0;
      mic_n_r <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      sw_r <= sw_nxt;
      int_pend_r <= int_pend_nxt;
      mic_n_r <= mic_n_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Outputs come straight from flip-flops, except int_n_o, which inverts int_pend_r, and sleep_o, which is decoded from state_r.
  assign int_n_o = ~int_pend_r;
  assign mic_found_n_o = mic_n_r;
  assign host_ready_o = ready_r;
  assign sw_o = sw_r;
  assign sleep_o = (state_r == HSD_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_sync_two_stage: assert property (
    ##2 jack_hi == $past(jack_detect_n_i, 2))
    else $error("Jack input not delayed by two stages.");

  a_debounce_start: assert property (
    state_r == HSD_SLEEP && !jack_hi && !host_start_i |=> state_r == HSD_DEBOUNCE)
    else $error("Debounce did not start on low jack.");

  a_debounce_restart: assert property (
    state_r == HSD_DEBOUNCE && jack_hi |=> state_r == HSD_SLEEP && tmr_r == '0)
    else $error("Debounce not restarted on high jack.");

  a_detect_start: assert property (
    state_r == HSD_DEBOUNCE && !jack_hi && expired(tmr_r, INS_TICKS, tick)
    |=> state_r == HSD_DETECT)
    else $error("Detection did not follow debounce expiry.");

  a_route_first: assert property (
    $fell(int_n_o) && $past(state_r) == HSD_ROUTE && state_r == HSD_ATTACHED
    |-> $stable(sw_o) && sw_o != SW_SLEEP)
    else $error("Interrupt asserted before routing settled.");

  a_mic_with_int: assert property (
    $fell(mic_found_n_o) |-> !int_n_o && $past(int_set) && $stable(sw_o))
    else $error("Mic_found_n not aligned with interrupt.");

  a_int_clear: assert property (
    !int_n_o && int_reg_read_i && !int_set |=> int_n_o)
    else $error("Interrupt not cleared by register read.");

  a_removal_act: assert property (
    state_r == HSD_ATTACHED && jack_hi && !host_start_i && !manual_ctrl_i
    |=> !int_n_o && mic_found_n_o && sw_o == SW_OFF && state_r == HSD_REMOVE_WAIT)
    else $error("Removal handling incorrect.");

  a_manual_hold: assert property (
    state_r == HSD_ATTACHED && jack_hi && !host_start_i && manual_ctrl_i |=> $stable(sw_o))
    else $error("Switches changed on removal under manual control.");

  a_depletion_wait: assert property (
    $rose(sw_o.depletion_on) |-> $past(state_r) == HSD_REMOVE_WAIT && $past(tmr_r) ==
    REM_TICKS - TMR_W'(1))
    else $error("Depletion FETs on before removal wait.");

  c_insert_mic: cover property (state_r == HSD_ROUTE ##1 !mic_found_n_o);
  c_insert_three: cover property (state_r == HSD_ROUTE ##1 mic_found_n_o && !int_n_o);
  c_bounce: cover property (state_r == HSD_DEBOUNCE ##1 state_r == HSD_SLEEP);
  c_back_sleep: cover property (state_r == HSD_REMOVE_WAIT ##1 state_r == HSD_SLEEP);

endmodule

// ### tb/hsd_host_jack_model.sv
// Host and jack-switch model facing the headset detect sequencer.
module hsd_host_jack_model (
  // Clock.
  input wire logic clk_i,
  // Scenario controls.
  input wire logic plugged_i,
  input wire logic [1:0] mic_sel_i,
  input wire logic ack_en_i,
  // Device side.
  input wire logic int_n_i,
  output logic jack_detect_n_o,
  output logic mic_on_sleeve_o,
  output logic mic_on_ring2_o,
  output logic int_reg_read_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // The jack pin has a pull-up, so an empty jack reads high.
  assign jack_detect_n_o = !plugged_i;
  // Comparators only see a mic while a plug is in.
  assign mic_on_sleeve_o = plugged_i & mic_sel_i[0];
  assign mic_on_ring2_o = plugged_i & mic_sel_i[1];

  // Host reads the interrupt register once per low interrupt, one cycle wide.
  initial int_reg_read_o = 1'b0;
  always @(negedge clk_i) begin
    int_reg_read_o <= ack_en_i && int_n_i === 1'b0 && !int_reg_read_o;
  end
endmodule

// ### tb/test_headset_detect_sequencer.sv
// Self-checking testbench for the headset detect sequencer.
module test_headset_detect_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import hsd_pkg::*;

  // A short tick keeps every interval cheap to simulate.
  localparam int TL = 20;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic host_start_i = 1'b0;
  logic manual_ctrl_i = 1'b0;
  logic plugged = 1'b0;
  logic ack_en = 1'b0;
  logic [1:0] mic_sel = 2'h0;
  logic jack_n, mic_s, mic_r, rd_pulse;
  logic int_n_o, mic_found_n_o, host_ready_o, sleep_o;
  hsd_sw_t sw_o;
  int n_fail = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Device and far side.
  hsd_seq #(.TICK_LEN(TL)) u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .jack_detect_n_i(jack_n), .mic_on_sleeve_i(mic_s), .mic_on_ring2_i(mic_r),
    .host_start_i(host_start_i), .int_reg_read_i(rd_pulse),
    .manual_ctrl_i(manual_ctrl_i), .int_n_o(int_n_o), .mic_found_n_o(mic_found_n_o),
    .host_ready_o(host_ready_o), .sleep_o(sleep_o), .sw_o(sw_o));
  hsd_host_jack_model u_far (.clk_i(clk_sys_i), .plugged_i(plugged), .mic_sel_i(mic_sel),
    .ack_en_i(ack_en), .int_n_i(int_n_o), .jack_detect_n_o(jack_n),
    .mic_on_sleeve_o(mic_s), .mic_on_ring2_o(mic_r), .int_reg_read_o(rd_pulse));

  // Clock of 50 ns period.
  initial forever #25 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Waits for interrupt low (0), sleep (1) or host ready (2), counting cycles.
  task wait_for(input int which, input int lim, output int n);
    n = 0;
    while (!((which == 0 && int_n_o === 1'b0) || (which == 1 && sleep_o === 1'b1) ||
             (which == 2 && host_ready_o === 1'b1))) begin
      cyc(1);
      n++;
      if (n > lim) begin
        n_fail++;
        $display("MISMATCH t=%0t wait %0d timed out", $time, which);
        tally_and_finish();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_insert(input logic [1:0] m, input hsd_sw_t esw, input logic emic);
    int n;
    mic_sel = m;
    plugged = 1'b1;
    wait_for(0, 215 * TL, n);
    chk(n >= 169 * TL && n <= 210 * TL, 1, "insert to interrupt");
    chk(sw_o, esw, "routing");
    chk(mic_found_n_o, emic, "mic_found_n");
  endtask

  // Interrupt holds until the host reads, then clears.
  task t_ack;
    cyc(5);
    chk(int_n_o, 0, "int held");
    ack_en = 1'b1;
    cyc(3);
    chk(int_n_o, 1, "int cleared");
    ack_en = 1'b0;
  endtask

  task t_remove(input logic man);
    int n;
    hsd_sw_t keep;
    keep = sw_o;
    manual_ctrl_i = man;
    plugged = 1'b0;
    cyc(4);
    chk(sw_o, man ? keep : SW_OFF, "removal switches");
    chk(int_n_o, 0, "removal int");
    chk(mic_found_n_o, 1, "mic released");
    if (!man) begin
      wait_for(1, 66 * TL, n);
      chk(n >= 48 * TL && n <= 61 * TL, 1, "removal wait");
      chk(sw_o, SW_SLEEP, "sleep switches");
    end else begin
      cyc(60 * TL);
      chk(sleep_o, 0, "manual no sleep");
      chk(sw_o, keep, "manual keeps");
    end
  endtask

  // A host command in sleep starts detection at once, skipping the debounce.
  task t_host_start;
    int n;
    mic_sel = 2'h1;
    plugged = 1'b1;
    cyc(2);
    host_start_i = 1'b1;
    cyc(1);
    host_start_i = 1'b0;
    wait_for(0, 90 * TL, n);
    chk(n >= 79 * TL && n <= 82 * TL, 1, "host start to interrupt");
    chk(sw_o, SW_MIC_SLEEVE, "host start routing");
    chk(mic_found_n_o, 0, "host start mic");
  endtask

  // Removal in mid-detection takes the removal path at once.
  task t_abort;
    plugged = 1'b1;
    cyc(130 * TL);
    chk(int_n_o, 1, "no int in detect");
    t_remove(1'b0);
  endtask

  // A bounce in mid-debounce restarts the whole interval.
  task t_bounce;
    int n;
    plugged = 1'b1;
    cyc(40 * TL);
    plugged = 1'b0;
    cyc(4);
    chk(sleep_o, 1, "bounce back to sleep");
    chk(int_n_o, 1, "bounce no int");
    plugged = 1'b1;
    wait_for(0, 215 * TL, n);
    chk(n >= 169 * TL, 1, "restarted debounce");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    cyc(12);
    sys_rst_i = 1'b0;
    wait_for(2, 26 * TL, n);
    chk(n <= 25 * TL, 1, "host ready");
    t_insert(2'h1, SW_MIC_SLEEVE, 1'b0);
    t_ack();
    t_remove(1'b0);
    t_ack();
    t_insert(2'h2, SW_MIC_RING2, 1'b0);
    t_ack();
    t_remove(1'b0);
    t_ack();
    t_insert(2'h0, SW_THREE, 1'b1);
    t_ack();
    t_remove(1'b0);
    t_ack();
    t_insert(2'h3, SW_THREE, 1'b1);
    t_ack();
    t_remove(1'b0);
    t_ack();
    t_host_start();
    t_ack();
    t_remove(1'b0);
    t_ack();
    t_abort();
    t_ack();
    t_bounce();
    t_ack();
    t_remove(1'b1);
    tally_and_finish();
  end
endmodule
